// *** rtl/timer_evt_cmp_defines.vh ***
// Register map, field positions, reset values and widths of the event and compare block
`ifndef TIMER_EVT_CMP_DEFINES_VH
`define TIMER_EVT_CMP_DEFINES_VH

// Byte offsets of the Avalon-MM registers
`define OFF_EVENT_FLAG_STATUS    8'h10
`define OFF_SOFTWARE_EVENT_TRIG  8'h14
`define OFF_CHAN_PAIR_CTL_LOW    8'h18
`define OFF_CAPCMP_VALUE0        8'h34
`define OFF_CAPCMP_VALUE1        8'h38

// Event flag status bits
`define BIT_UPDATE_FLAG          0
`define BIT_CAPCMP_FLAG0         1
`define BIT_TRIGGER_FLAG         6
`define BIT_OVERCAPTURE_FLAG0    9

// Software event trigger bits
`define BIT_UPDATE_GEN           0
`define BIT_CAPCMP_GEN0          1
`define BIT_TRIGGER_GEN          6

// Channel pair control field positions, relative to the channel base
`define CHAN_FIELD_STRIDE        8
`define FLD_MODE_SELECT          0
`define FLD_SHADOW_ENABLE        3
`define FLD_OUTPUT_CONTROL       4
`define FLD_CLEAR_ENABLE         7

// Channel mode and compare output control encodings
`define MODE_OUTPUT              2'b00
`define OCTL_TIMING              3'b000
`define OCTL_SET_ON_MATCH        3'b001
`define OCTL_CLEAR_ON_MATCH      3'b010
`define OCTL_TOGGLE_ON_MATCH     3'b011
`define OCTL_FORCE_LOW           3'b100
`define OCTL_FORCE_HIGH          3'b101
`define OCTL_PWM0                3'b110
`define OCTL_PWM1                3'b111

// Widths and reset values
`define COUNTER_WIDTH            16
`define CHAN_PAIR_CTL_RESET      16'h0000
`define CAPCMP_VALUE_RESET       16'h0000

`endif

// *** rtl/timer_evt_cmp.v ***
// Timer event flags, software events and output compare control for channels 0 and 1
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "timer_evt_cmp_defines.vh"

// Summary of operation
// - Capture on set channel flag raises overcapture
// - Pause mode: both trigger edges are events
// - Pause mode gates counter clock by trigger
// - Trigger flag set by hardware, cleared writing zero
// - Channel flag set on capture or compare
// - Input mode: reading capture value clears flag
// - Update flag set on update, software clears
// - Trigger generation sets flag, requests, self-clears
// - Channel generation: flag, capture, overcapture
// - Update generation clears or reloads counter, prescaler
// - Mode encoding; writable only while channel disabled
// - Compare clear forces prepare low on trigger
// - Prepare active high; outputs use polarity
// - Codes 000-011: hold, set, clear, toggle
// - Code 100 forces low, 101 forces high
// - PWM mode 0 levels by count direction
// - PWM mode 1 levels by count direction
// - PWM level changes only with compare result
// - Shadow enabled: compare loads at update event, except one coinciding with a value write
module timer_evt_cmp (
    // Clock and reset
    input  wire                       clk_i,
    input  wire                       rst_b_i,
    // Avalon-MM slave
    input  wire [7:0]                 address_i,
    input  wire                       read_i,
    input  wire                       write_i,
    input  wire [3:0]                 byteenable_i,
    input  wire [31:0]                writedata_i,
    output reg  [31:0]                readdata_o,
    output reg                        waitrequest_o,
    // Counter core
    input  wire [`COUNTER_WIDTH-1:0]  counter_value_i,
    input  wire                       count_down_i,
    input  wire                       center_aligned_i,
    input  wire                       update_event_i,
    output reg                        counter_clear_o,
    output reg                        counter_reload_o,
    output reg                        prescaler_clear_o,
    output reg                        counter_clock_enable_o,
    // Slave mode and trigger
    input  wire                       pause_mode_i,
    input  wire                       trigger_in_i,
    input  wire                       filtered_external_trigger_i,
    output reg                        trigger_event_o,
    output reg                        update_event_o,
    // Channels
    input  wire [1:0]                 capture_event_i,
    input  wire [1:0]                 chan_output_enable_i,
    input  wire [1:0]                 primary_polarity_i,
    input  wire [1:0]                 complementary_polarity_i,
    output reg  [1:0]                 capcmp_event_o,
    output reg  [1:0]                 output_prepare_signal_o,
    output reg  [1:0]                 chan_out_o,
    output reg  [1:0]                 chan_out_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Byte lane mask for writes
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Write-zero-to-clear decode of one status bit
    function clear_by_zero;
        input        wr;
        input [31:0] mask;
        input [31:0] data;
        input integer pos;
        begin
            clear_by_zero = wr & mask[pos] & ~data[pos];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: waitrequest drops one cycle after a request, access taken then
    wire        access       = (read_i | write_i) & ~waitrequest_o;
    wire        rd_acc       = read_i & access;
    wire        wr_acc       = write_i & access;
    wire [31:0] wmask        = lane_mask(byteenable_i);
    wire        wr_flags     = wr_acc & (address_i == `OFF_EVENT_FLAG_STATUS);
    wire        wr_swevt     = wr_acc & (address_i == `OFF_SOFTWARE_EVENT_TRIG);
    wire        wr_ctl       = wr_acc & (address_i == `OFF_CHAN_PAIR_CTL_LOW);

    reg  [15:0] chan_pair_control_low;
    reg         update_event_flag;
    reg         trigger_event_flag;
    reg  [1:0]  chan_capcmp_flag;
    reg  [1:0]  chan_overcapture_flag;
    reg         trigger_d;
    wire [15:0] ccv_shadow0;
    wire [15:0] ccv_shadow1;

    // Software generation bits act in the accept cycle and are never stored
    wire        update_gen_bit  = wr_swevt & wmask[`BIT_UPDATE_GEN] &
                                  writedata_i[`BIT_UPDATE_GEN];
    wire        trigger_gen_bit = wr_swevt & wmask[`BIT_TRIGGER_GEN] &
                                  writedata_i[`BIT_TRIGGER_GEN];
    wire [1:0]  chan_capcmp_gen_bit = {2{wr_swevt}} &
                                  wmask[`BIT_CAPCMP_GEN0+1:`BIT_CAPCMP_GEN0] &
                                  writedata_i[`BIT_CAPCMP_GEN0+1:`BIT_CAPCMP_GEN0];

    wire [31:0] status_word;
    assign status_word = {21'h000000, chan_overcapture_flag, 2'b00, trigger_event_flag,
                          3'b000, chan_capcmp_flag, update_event_flag};

    reg  [31:0] next_readdata;
    always @* begin
        case (address_i)
            `OFF_EVENT_FLAG_STATUS:   next_readdata = status_word;
            `OFF_SOFTWARE_EVENT_TRIG: next_readdata = 32'h00000000;
            `OFF_CHAN_PAIR_CTL_LOW:   next_readdata = {16'h0000, chan_pair_control_low};
            `OFF_CAPCMP_VALUE0:       next_readdata = {16'h0000, ccv_shadow0};
            `OFF_CAPCMP_VALUE1:       next_readdata = {16'h0000, ccv_shadow1};
            default:                  next_readdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h00000000;
        end else begin
            if ((read_i | write_i) & waitrequest_o) begin
                waitrequest_o <= 1'b0;
                readdata_o    <= read_i ? next_readdata : 32'h00000000;
            end else begin
                waitrequest_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel pair control; mode fields frozen while the channel is enabled
    reg [15:0] next_ctl;
    always @* begin
        next_ctl = (chan_pair_control_low & ~wmask[15:0]) | (writedata_i[15:0] & wmask[15:0]);
        if (chan_output_enable_i[0]) begin
            next_ctl[1:0] = chan_pair_control_low[1:0];
        end
        if (chan_output_enable_i[1]) begin
            next_ctl[9:8] = chan_pair_control_low[9:8];
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chan_pair_control_low <= `CHAN_PAIR_CTL_RESET;
        end else if (wr_ctl) begin
            chan_pair_control_low <= next_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger and update events
    wire trig_rise = trigger_in_i & ~trigger_d;
    wire trig_fall = ~trigger_in_i & trigger_d;
    wire hw_trigger = trig_rise | (pause_mode_i & trig_fall);
    wire trigger_evt = hw_trigger | trigger_gen_bit;
    wire update_evt = update_event_i | update_gen_bit;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trigger_d              <= 1'b0;
            trigger_event_flag     <= 1'b0;
            update_event_flag      <= 1'b0;
            trigger_event_o        <= 1'b0;
            update_event_o         <= 1'b0;
            counter_clear_o        <= 1'b0;
            counter_reload_o       <= 1'b0;
            prescaler_clear_o      <= 1'b0;
            counter_clock_enable_o <= 1'b1;
        end else begin
            trigger_d <= trigger_in_i;
            // Set wins over a simultaneous software clear
            trigger_event_flag <= trigger_evt | (trigger_event_flag &
                ~clear_by_zero(wr_flags, wmask, writedata_i, `BIT_TRIGGER_FLAG));
            update_event_flag <= update_evt | (update_event_flag &
                ~clear_by_zero(wr_flags, wmask, writedata_i, `BIT_UPDATE_FLAG));
            trigger_event_o <= trigger_evt;
            update_event_o  <= update_evt;
            counter_clear_o   <= update_gen_bit & (~count_down_i | center_aligned_i);
            counter_reload_o  <= update_gen_bit & count_down_i & ~center_aligned_i;
            prescaler_clear_o <= update_gen_bit;
            counter_clock_enable_o <= pause_mode_i ? trigger_in_i : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel capture, compare and output prepare logic
    wire [31:0] shadow_bus;
    assign ccv_shadow0 = shadow_bus[15:0];
    assign ccv_shadow1 = shadow_bus[31:16];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            localparam integer BASE = ch * `CHAN_FIELD_STRIDE;
            wire [1:0] mode  = chan_pair_control_low[BASE+`FLD_MODE_SELECT +: 2];
            wire [2:0] octl  = chan_pair_control_low[BASE+`FLD_OUTPUT_CONTROL +: 3];
            wire       shen  = chan_pair_control_low[BASE+`FLD_SHADOW_ENABLE];
            wire       clren = chan_pair_control_low[BASE+`FLD_CLEAR_ENABLE];
            wire       in_mode = (mode != `MODE_OUTPUT);
            wire [7:0] ccv_addr = (ch == 0) ? `OFF_CAPCMP_VALUE0 : `OFF_CAPCMP_VALUE1;

            reg  [15:0] shadow;
            reg  [15:0] active;
            reg         match_d;

            wire match   = (counter_value_i == active);
            wire cmp_evt = ~in_mode & match & ~match_d;
            wire cap_evt = in_mode & (capture_event_i[ch] | chan_capcmp_gen_bit[ch]);
            wire set_flag = cap_evt | cmp_evt | chan_capcmp_gen_bit[ch];
            wire rd_clr  = rd_acc & (address_i == ccv_addr) & in_mode;
            wire wr_ccv  = wr_acc & (address_i == ccv_addr) & ~in_mode;
            wire [15:0] ccv_wdata = (shadow & ~wmask[15:0]) | (writedata_i[15:0] & wmask[15:0]);
            wire clr_flag = clear_by_zero(wr_flags, wmask, writedata_i, `BIT_CAPCMP_FLAG0 + ch);
            wire clr_ovc  = clear_by_zero(wr_flags, wmask, writedata_i,
                                          `BIT_OVERCAPTURE_FLAG0 + ch);
            wire pwm_high = count_down_i ? (counter_value_i <= active)
                                         : (counter_value_i < active);

            reg next_prep;
            always @* begin
                next_prep = output_prepare_signal_o[ch];
                case (octl)
                    `OCTL_TIMING:          next_prep = output_prepare_signal_o[ch];
                    `OCTL_SET_ON_MATCH:    if (cmp_evt) next_prep = 1'b1;
                    `OCTL_CLEAR_ON_MATCH:  if (cmp_evt) next_prep = 1'b0;
                    `OCTL_TOGGLE_ON_MATCH: if (cmp_evt) next_prep = ~next_prep;
                    `OCTL_FORCE_LOW:       next_prep = 1'b0;
                    `OCTL_FORCE_HIGH:      next_prep = 1'b1;
                    // Level follows the compare result only, so it moves only on change
                    `OCTL_PWM0:            next_prep = pwm_high;
                    `OCTL_PWM1:            next_prep = ~pwm_high;
                    default:               next_prep = output_prepare_signal_o[ch];
                endcase
                if (clren & filtered_external_trigger_i) begin
                    next_prep = 1'b0;
                end
            end

            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    shadow                      <= `CAPCMP_VALUE_RESET;
                    active                      <= `CAPCMP_VALUE_RESET;
                    match_d                     <= 1'b0;
                    chan_capcmp_flag[ch]        <= 1'b0;
                    chan_overcapture_flag[ch]   <= 1'b0;
                    capcmp_event_o[ch]          <= 1'b0;
                    output_prepare_signal_o[ch] <= 1'b0;
                    chan_out_o[ch]              <= 1'b0;
                    chan_out_n_o[ch]            <= 1'b1;
                end else begin
                    match_d <= match;
                    if (cap_evt) begin
                        shadow <= counter_value_i;
                        active <= counter_value_i;
                    end else if (wr_ccv) begin
                        shadow <= ccv_wdata;
                        if (!shen) begin
                            active <= ccv_wdata;
                        end
                    end else if (update_evt & shen & ~in_mode) begin
                        active <= shadow;
                    end
                    chan_capcmp_flag[ch] <= set_flag |
                        (chan_capcmp_flag[ch] & ~rd_clr & ~clr_flag);
                    chan_overcapture_flag[ch] <= (cap_evt & chan_capcmp_flag[ch]) |
                        (chan_overcapture_flag[ch] & ~clr_ovc);
                    capcmp_event_o[ch]          <= set_flag;
                    output_prepare_signal_o[ch] <= next_prep;
                    chan_out_o[ch]   <= next_prep ^ primary_polarity_i[ch];
                    chan_out_n_o[ch] <= ~next_prep ^ complementary_polarity_i[ch];
                end
            end

            assign shadow_bus[16*ch +: 16] = shadow;
        end
    endgenerate

endmodule // timer_evt_cmp

// *** dv/timer_evt_cmp_sva.sv ***
// Assertion checker for the timer event and compare block
`timescale 1ns/1ps
`include "timer_evt_cmp_defines.vh"
module timer_evt_cmp_sva (
    // Clock, reset and bus
    input wire        clk_i,
    input wire        rst_b_i,
    input wire [7:0]  address_i,
    input wire        read_i,
    input wire        write_i,
    input wire [3:0]  byteenable_i,
    input wire [31:0] writedata_i,
    input wire [31:0] readdata_o,
    input wire        waitrequest_o,
    // Counter, trigger and channels
    input wire        update_event_i,
    input wire        pause_mode_i,
    input wire        trigger_in_i,
    input wire        counter_clear_o,
    input wire        counter_reload_o,
    input wire        prescaler_clear_o,
    input wire        counter_clock_enable_o,
    input wire        trigger_event_o,
    input wire        update_event_o,
    input wire [1:0]  primary_polarity_i,
    input wire [1:0]  capcmp_event_o,
    input wire [1:0]  output_prepare_signal_o,
    input wire [1:0]  chan_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire sw_wr = write_i && !waitrequest_o && address_i == `OFF_SOFTWARE_EVENT_TRIG
                 && byteenable_i[0];
    ////////////////////////////////////////////////////////////////////////////
    property p_gate;
        $past(rst_b_i) |-> counter_clock_enable_o ==
            ($past(pause_mode_i) ? $past(trigger_in_i) : 1'b1);
    endproperty
    a_gate: assert property (p_gate) else $error("counter clock gate wrong");
    property p_trig_rise;
        $past(rst_b_i) && !pause_mode_i && $rose(trigger_in_i) |-> ##[1:3] trigger_event_o;
    endproperty
    a_trig_rise: assert property (p_trig_rise) else $error("no trigger on rise");
    property p_trig_fall;
        $past(rst_b_i) && pause_mode_i && $past(pause_mode_i) && $fell(trigger_in_i)
            |-> ##[1:3] trigger_event_o;
    endproperty
    a_trig_fall: assert property (p_trig_fall) else $error("no trigger on fall");
    property p_pol;
        $past(rst_b_i, 2) && $stable(output_prepare_signal_o) && $stable(primary_polarity_i)
            |-> chan_out_o == (output_prepare_signal_o ^ primary_polarity_i);
    endproperty
    a_pol: assert property (p_pol) else $error("output polarity wrong");
    property p_upd_sw;
        prescaler_clear_o |-> counter_clear_o != counter_reload_o;
    endproperty
    a_upd_sw: assert property (p_upd_sw) else $error("update clear or reload wrong");
    property p_upd_hw;
        update_event_i |-> ##[1:2] update_event_o;
    endproperty
    a_upd_hw: assert property (p_upd_hw) else $error("update event lost");
    property p_trg_gen;
        sw_wr && writedata_i[6] |-> ##[1:3] trigger_event_o;
    endproperty
    a_trg_gen: assert property (p_trg_gen) else $error("trigger generation lost");
    property p_cc_gen;
        sw_wr && writedata_i[1] |-> ##[1:3] capcmp_event_o[0];
    endproperty
    a_cc_gen: assert property (p_cc_gen) else $error("channel generation lost");
    property p_gen_rd;
        read_i && !waitrequest_o && address_i == `OFF_SOFTWARE_EVENT_TRIG |-> readdata_o == 0;
    endproperty
    a_gen_rd: assert property (p_gen_rd) else $error("generation reg not zero");
    c_trig: cover property (trigger_event_o);
    c_reload: cover property (counter_reload_o);
    c_cc: cover property (capcmp_event_o[0]);
endmodule // timer_evt_cmp_sva
bind timer_evt_cmp timer_evt_cmp_sva u_sva (.clk_i, .rst_b_i, .address_i, .read_i, .write_i,
    .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .update_event_i, .pause_mode_i,
    .trigger_in_i, .counter_clear_o, .counter_reload_o, .prescaler_clear_o,
    .counter_clock_enable_o, .trigger_event_o, .update_event_o, .primary_polarity_i,
    .capcmp_event_o, .output_prepare_signal_o, .chan_out_o);

// *** dv/timer_evt_cmp_bench.sv ***
// Self-checking bench for the timer event and compare block
`timescale 1ns/1ps
`include "timer_evt_cmp_defines.vh"
module timer_evt_cmp_bench;
    localparam [7:0] FLG = `OFF_EVENT_FLAG_STATUS, SWE = `OFF_SOFTWARE_EVENT_TRIG;
    localparam [7:0] CTL = `OFF_CHAN_PAIR_CTL_LOW, CV0 = `OFF_CAPCMP_VALUE0;
    reg clk_i = 0, rst_b_i = 0, read_i = 0, write_i = 0, count_down_i = 0;
    reg center_aligned_i = 0, update_event_i = 0, pause_mode_i = 0, trigger_in_i = 0;
    reg filtered_external_trigger_i = 0;
    reg [7:0]  address_i = 0;
    reg [3:0]  byteenable_i = 4'hF;
    reg [31:0] writedata_i = 0;
    reg [15:0] counter_value_i = 0;
    reg [1:0]  capture_event_i = 0, chan_output_enable_i = 0;
    reg [1:0]  primary_polarity_i = 0, complementary_polarity_i = 0;
    wire [31:0] readdata_o;
    wire waitrequest_o, counter_clear_o, counter_reload_o, prescaler_clear_o;
    wire counter_clock_enable_o, trigger_event_o, update_event_o;
    wire [1:0] capcmp_event_o, output_prepare_signal_o, chan_out_o, chan_out_n_o;
    int err_count = 0, total_checks = 0, cyc = 0;
    timer_evt_cmp u_dut (.clk_i, .rst_b_i, .address_i, .read_i, .write_i, .byteenable_i,
        .writedata_i, .readdata_o, .waitrequest_o, .counter_value_i, .count_down_i,
        .center_aligned_i, .update_event_i, .counter_clear_o, .counter_reload_o,
        .prescaler_clear_o, .counter_clock_enable_o, .pause_mode_i, .trigger_in_i,
        .filtered_external_trigger_i, .trigger_event_o, .update_event_o, .capture_event_i,
        .chan_output_enable_i, .primary_polarity_i, .complementary_polarity_i, .capcmp_event_o,
        .output_prepare_signal_o, .chan_out_o, .chan_out_n_o);
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            $display("[ERR] %0t timeout", $time);
            err_count++;
            end_sim;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Request held until waitrequest is sampled low, released at that edge
    task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        @(posedge clk_i);
        address_i <= a;
        write_i <= w;
        read_i <= !w;
        writedata_i <= d;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) @(posedge clk_i);
        q = readdata_o;
        write_i <= 0;
        read_i <= 0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        bus(1, a, d, q);
    endtask
    task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
        reg [31:0] q;
        bus(0, a, 0, q);
        chk(q & m, e);
    endtask
    // Prepare level {below, at match, above counting down} per control code
    function [2:0] exp_prep(input int c);
        exp_prep = 24'h738718 >> (c * 3);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reg [31:0] q;
        reg [15:0] cv;
        int k;
        q = $urandom(32'h580E8966);
        primary_polarity_i <= 2'($urandom);
        complementary_polarity_i <= 2'($urandom);
        tick(2);
        rst_b_i <= 1;
        rdc(CTL, 32'hFFFF, 0);
        rdc(8'h00, 32'hFFFFFFFF, 0);
        wr(FLG, 0);
        update_event_i <= 1;
        tick(1);
        update_event_i <= 0;
        rdc(FLG, 1, 1);
        wr(FLG, 32'hFFFFFFFF);
        rdc(FLG, 1, 1);
        wr(FLG, 32'hFFFFFFFE);
        rdc(FLG, 1, 0);
        wr(SWE, 32'h40);
        rdc(FLG, 32'h40, 32'h40);
        rdc(SWE, 32'hFFFFFFFF, 0);
        wr(FLG, 32'hFFFFFFBF);
        rdc(FLG, 32'h40, 0);
        for (k = 0; k < 4; k++) begin
            pause_mode_i <= k[1];
            trigger_in_i <= !k[0];
            tick(4);
            wr(FLG, 0);
            trigger_in_i <= k[0];
            tick(4);
            chk(counter_clock_enable_o, k[1] ? k[0] : 1);
            rdc(FLG, 32'h40, (k[1] || k[0]) ? 32'h40 : 0);
        end
        pause_mode_i <= 0;
        for (k = 0; k < 3; k++) begin
            count_down_i <= k == 1;
            center_aligned_i <= k == 2;
            wr(FLG, 0);
            wr(SWE, 1);
            @(negedge clk_i);
            chk({prescaler_clear_o, counter_clear_o, counter_reload_o}, k == 1 ? 5 : 6);
            rdc(FLG, 1, 1);
        end
        {count_down_i, center_aligned_i} <= 0;
        cv = $urandom_range(60000, 100);
        wr(CV0, cv);
        for (k = 0; k < 8; k++) begin
            wr(CTL, k == 2 ? 32'h50 : 32'h40);
            wr(CTL, 0);
            counter_value_i <= cv - 1;
            wr(CTL, (k << 4) | (k > 5 ? 8 : 0));
            tick(3);
            chk(output_prepare_signal_o[0], exp_prep(k) >> 2);
            wr(FLG, 32'hFFFFFFFD);
            counter_value_i <= cv;
            tick(3);
            chk(output_prepare_signal_o[0], exp_prep(k) >> 1 & 1);
            rdc(FLG, 2, 2);
            count_down_i <= 1;
            counter_value_i <= cv + 1;
            tick(3);
            chk(output_prepare_signal_o[0], exp_prep(k) & 1);
            count_down_i <= 0;
        end
        filtered_external_trigger_i <= 1;
        wr(CTL, 32'h50D0);
        tick(3);
        chk(output_prepare_signal_o[0], 0);
        chk(output_prepare_signal_o[1], 1);
        filtered_external_trigger_i <= 0;
        tick(3);
        chk(output_prepare_signal_o[0], 1);
        chk(chan_out_o[0], !primary_polarity_i[0]);
        chk(chan_out_n_o[0], complementary_polarity_i[0]);
        wr(CTL, 0);
        counter_value_i <= cv + 10;
        wr(CTL, 32'h68);
        wr(CV0, cv + 20);
        tick(3);
        chk(output_prepare_signal_o[0], 0);
        update_event_i <= 1;
        tick(1);
        update_event_i <= 0;
        tick(3);
        chk(output_prepare_signal_o[0], 1);
        wr(CTL, 1);
        wr(FLG, 0);
        for (k = 0; k < 2; k++) begin
            capture_event_i <= 2'b01;
            tick(1);
            capture_event_i <= 0;
            tick(2);
        end
        rdc(FLG, 32'h202, 32'h202);
        rdc(CV0, 32'hFFFF, cv + 10);
        rdc(FLG, 2, 0);
        counter_value_i <= 16'($urandom);
        wr(FLG, 0);
        wr(SWE, 2);
        wr(SWE, 2);
        rdc(FLG, 32'h202, 32'h202);
        rdc(CV0, 32'hFFFF, counter_value_i);
        for (k = 0; k < 4; k++) begin
            wr(CTL, k * 257);
            rdc(CTL, 32'h303, k * 257);
        end
        chan_output_enable_i <= 2'b11;
        wr(CTL, 0);
        rdc(CTL, 32'h303, 32'h303);
        end_sim;
    end
endmodule // timer_evt_cmp_bench
